/* File: embedded_ram_block.sv */
/*
 * Embedded RAM block of 9216 bits with two ports sharing one clock.
 * Assumes user logic holds the mode and shapes steady while ports are
 * used, and that a flash read returns its word in the cycle its request is high.
 */
module embedded_ram_block
    import ram_pkg::*;
(
    input wire logic clk, // Block clock, 40 MHz
    input wire logic sys_rst, // Synchronous reset, high
    input wire ram_pkg::ram_mode_t cfg_mode, // Memory mode
    input wire ram_pkg::port_cfg_t cfg_a, // Port A shape and output option
    input wire ram_pkg::port_cfg_t cfg_b, // Port B shape and output option
    input wire ram_pkg::port_req_t req_a, // Port A request
    input wire ram_pkg::port_req_t req_b, // Port B request
    output logic [ram_pkg::DATA_W-1:0] rdata_a, // Port A read data
    output logic [ram_pkg::DATA_W-1:0] rdata_b, // Port B read data
    input wire logic init_start, // Pulse: begin preload
    input wire logic init_zero, // Preload with all zeros
    input wire logic [ram_pkg::REGION_W-1:0] init_region, // Shared pattern region
    output logic flash_rd_en, // Read request to user flash store
    output logic [ram_pkg::FLASH_ADDR_W-1:0] flash_rd_addr, // Flash word address
    input wire logic [ram_pkg::DATA_W-1:0] flash_rd_data, // Flash word, same cycle as request
    output logic init_done // High when the ports may be used
);
    import ram_pkg::*;

    typedef struct packed {
        init_state_t state;
        logic [INIT_CNT_W-1:0] cnt;
        logic [REGION_W-1:0] region;
        logic rd_en;
        logic [FLASH_ADDR_W-1:0] rd_addr;
        logic done;
    } ctrl_t;

    ctrl_t st_reg;
    ctrl_t st_next;
    logic mem [0:ARRAY_BITS-1];
    logic wide_ok;
    logic [4:0] wa;
    logic [4:0] wb;
    logic wr_a_ok;
    logic wr_b_ok;
    port_req_t cap_a;
    port_req_t cap_b;
    logic [DATA_W-1:0] arr_a;
    logic [DATA_W-1:0] arr_b;
    logic init_we;
    logic [DATA_W-1:0] init_data;

    //-----------------------------------------------------------
    // Shapes and write permission
    //-----------------------------------------------------------
    // The 18-bit shape needs the second port's data path, so it is
    // folded to x9 in the single-port and true dual modes
    assign wide_ok = (cfg_mode == MODE_PSEUDO_DUAL) || (cfg_mode == MODE_FIFO);
    assign wa = (cfg_a.shape == SHAPE_X18 && !wide_ok) ? 5'h09 : width_of(cfg_a.shape);
    assign wb = (cfg_b.shape == SHAPE_X18 && !wide_ok) ? 5'h09 : width_of(cfg_b.shape);
    // Port A writes in every mode; port B writes only in true dual
    assign wr_a_ok = st_reg.done;
    assign wr_b_ok = st_reg.done && (cfg_mode == MODE_TRUE_DUAL);

    port_stage u_port_a (
        .clk(clk),
        .sys_rst(sys_rst),
        .req(req_a),
        .cfg(cfg_a),
        .write_allow(wr_a_ok),
        .arr_rdata(arr_a),
        .cap(cap_a),
        .rdata(rdata_a)
    );

    port_stage u_port_b (
        .clk(clk),
        .sys_rst(sys_rst),
        .req(req_b),
        .cfg(cfg_b),
        .write_allow(wr_b_ok),
        .arr_rdata(arr_b),
        .cap(cap_b),
        .rdata(rdata_b)
    );

    //-----------------------------------------------------------
    // Array read
    //-----------------------------------------------------------
    // Bit i of word n sits at n*width+i for every port width
    always_comb begin
        int unsigned ia;
        int unsigned ib;
        ia = 0;
        ib = 0;
        arr_a = DATA_RST;
        arr_b = DATA_RST;
        for (int unsigned i = 0; i < DATA_W; i++) begin
            ia = int'(cap_a.addr) * int'(wa) + i;
            ib = int'(cap_b.addr) * int'(wb) + i;
            if (i < wa && ia < ARRAY_BITS) begin
                arr_a[i] = mem[ia];
            end
            if (i < wb && ib < ARRAY_BITS) begin
                arr_b[i] = mem[ib];
            end
        end
    end

    //-----------------------------------------------------------
    // Array write
    //-----------------------------------------------------------
    // On a clash between ports of equal width port B is applied last and wins
    always_ff @(posedge clk) begin
        for (int unsigned i = 0; i < DATA_W; i++) begin
            if (init_we) begin
                mem[int'(st_reg.cnt) * DATA_W + i] <= init_data[i];
            end else begin
                if (cap_a.we && i < wa && int'(cap_a.addr) * int'(wa) + i < ARRAY_BITS) begin
                    mem[int'(cap_a.addr) * int'(wa) + i] <= cap_a.wdata[i];
                end
                if (cap_b.we && i < wb && int'(cap_b.addr) * int'(wb) + i < ARRAY_BITS) begin
                    mem[int'(cap_b.addr) * int'(wb) + i] <= cap_b.wdata[i];
                end
            end
        end
    end

    //-----------------------------------------------------------
    // Preload sequencer
    //-----------------------------------------------------------
    // A zero pattern is written locally so it costs no flash space;
    // other patterns come from a region that blocks may share
    assign init_we = (st_reg.state == INIT_CLEAR) || (st_reg.state == INIT_STORE);
    assign init_data = (st_reg.state == INIT_STORE) ? flash_rd_data : DATA_RST;

    always_comb begin
        st_next = st_reg;
        st_next.rd_en = 1'b0;
        unique case (st_reg.state)
            INIT_IDLE: begin
                if (init_start) begin
                    st_next.done = 1'b0;
                    st_next.cnt = CNT_RST;
                    st_next.region = init_region;
                    st_next.state = init_zero ? INIT_CLEAR : INIT_FETCH;
                end
            end
            INIT_CLEAR: begin
                st_next.cnt = st_reg.cnt + 9'h001;
                if (st_reg.cnt == INIT_LAST) begin
                    st_next.state = INIT_IDLE;
                    st_next.done = 1'b1;
                end
            end
            INIT_FETCH: begin
                st_next.rd_en = 1'b1;
                st_next.rd_addr = {st_reg.region, st_reg.cnt};
                st_next.state = INIT_STORE;
            end
            INIT_STORE: begin
                if (st_reg.rd_en) begin
                    st_next.cnt = st_reg.cnt + 9'h001;
                    st_next.state = (st_reg.cnt == INIT_LAST) ? INIT_IDLE : INIT_FETCH;
                    st_next.done = (st_reg.cnt == INIT_LAST);
                end
            end
            default: begin
                st_next.state = INIT_IDLE;
                st_next.done = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '{state: INIT_IDLE, cnt: CNT_RST, region: REGION_RST,
                        rd_en: 1'b0, rd_addr: FLASH_ADDR_RST, done: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    assign flash_rd_en = st_reg.rd_en;
    assign flash_rd_addr = st_reg.rd_addr;
    assign init_done = st_reg.done;

    //-----------------------------------------------------------
    // Checks
    //-----------------------------------------------------------
    a_zero_no_flash: assert property (@(posedge clk) disable iff (sys_rst)
        st_reg.state == INIT_CLEAR |-> !flash_rd_en)
        else $error("Zero preload touched flash");
    a_shared_region: assert property (@(posedge clk) disable iff (sys_rst)
        flash_rd_en |-> flash_rd_addr[FLASH_ADDR_W-1:INIT_CNT_W] == st_reg.region)
        else $error("Flash read outside chosen region");
    a_fetch_store: assert property (@(posedge clk) disable iff (sys_rst)
        flash_rd_en |-> st_reg.state == INIT_STORE ##1 !flash_rd_en)
        else $error("Flash word not stored");
    a_clear_length: assert property (@(posedge clk) disable iff (sys_rst)
        (init_start && init_zero && init_done) |=> !init_done [*8] ##[505:505] init_done)
        else $error("Zero preload length wrong");
    a_shape_limit: assert property (@(posedge clk) disable iff (sys_rst)
        !wide_ok |-> wa <= 5'h09 && wb <= 5'h09)
        else $error("18-bit shape in symmetric mode");
    a_bit_order: assert property (@(posedge clk) disable iff (sys_rst)
        (cap_a.we && wa == 5'h01 && !cap_b.we && !init_we)
        |=> mem[$past(cap_a.addr)] == $past(cap_a.wdata[0]))
        else $error("Single-bit write landed elsewhere");

endmodule

/* File: embedded_ram_block_tb.sv */
/*
 * Self-checking bench for the embedded RAM block and its flash model.
 * Assumes the block's package and the flash store model are compiled first.
 */
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin bad_count++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module embedded_ram_block_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ram_pkg::*;

    logic clk = 0;
    logic sys_rst = 1;
    ram_mode_t cfg_mode = MODE_SINGLE;
    port_cfg_t cfg_a = '0;
    port_cfg_t cfg_b = '0;
    port_req_t req_a = REQ_RST;
    port_req_t req_b = REQ_RST;
    logic [DATA_W-1:0] rdata_a, rdata_b, flash_rd_data, got;
    logic init_start = 0;
    logic init_zero = 0;
    logic [REGION_W-1:0] init_region = '0;
    logic flash_rd_en, init_done;
    logic [FLASH_ADDR_W-1:0] flash_rd_addr;
    int bad_count = 0;
    int tests_run = 0;
    int nflash = 0;

    embedded_ram_block u_embedded_ram_block (.clk(clk), .sys_rst(sys_rst),
        .cfg_mode(cfg_mode), .cfg_a(cfg_a), .cfg_b(cfg_b), .req_a(req_a),
        .req_b(req_b), .rdata_a(rdata_a), .rdata_b(rdata_b), .init_start(init_start),
        .init_zero(init_zero), .init_region(init_region), .flash_rd_en(flash_rd_en),
        .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data),
        .init_done(init_done));

    flash_store_model u_flash_store_model (.clk(clk), .rd_en(flash_rd_en),
        .rd_addr(flash_rd_addr), .rd_data(flash_rd_data));

    //-----------------------------------------------------------
    // Clock and flash request counter
    //-----------------------------------------------------------
    initial begin
        forever #12.5 clk = ~clk;
    end

    // Counted mid-cycle, where the one-cycle request stands settled
    always @(negedge clk) begin
        if (flash_rd_en === 1'b1) nflash <= nflash + 1;
    end

    //-----------------------------------------------------------
    // Port helpers
    //-----------------------------------------------------------
    // Requests change at the falling edge; the caller may chain writes
    // Idle lets one edge pass, so the next request is a fresh assignment
    task automatic idle();
        req_a = REQ_RST;
        req_b = REQ_RST;
        @(negedge clk);
    endtask

    task automatic wr(input bit b, input logic [12:0] a, input logic [17:0] d);
        port_req_t r;
        r = '{1'b1, 1'b1, a, d};
        if (b) req_b = r;
        else req_a = r;
        @(negedge clk);
    endtask

    // Read data is sampled lat cycles after the capture edge
    task automatic rd(input bit b, input logic [12:0] a, input int lat);
        port_req_t r;
        r = '{1'b1, 1'b0, a, 18'h00000};
        if (b) req_b = r;
        else req_a = r;
        @(negedge clk);
        if (b) req_b = REQ_RST;
        else req_a = REQ_RST;
        repeat (lat) @(negedge clk);
        got = b ? rdata_b : rdata_a;
    endtask

    task automatic report_and_stop();
        $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // A preload that never finishes ends the run
    task automatic preload(input logic z, input logic [3:0] reg_id);
        int i;
        init_zero = z;
        init_region = reg_id;
        init_start = 1'b1;
        @(negedge clk);
        init_start = 1'b0;
        `CHK("init_busy", 1'b0, init_done)
        for (i = 0; i < 3000 && init_done !== 1'b1; i++) @(negedge clk);
        if (init_done !== 1'b1) begin
            bad_count++;
            report_and_stop();
        end
    endtask

    //-----------------------------------------------------------
    // Scenarios
    //-----------------------------------------------------------
    // Narrow writes on A land inside a wide word read on B, and back
    task automatic t_mixed();
        logic [8:0] pat;
        logic [8:0] pb;
        pat = 9'h1a5;
        pb = 9'h0f3;
        cfg_mode = MODE_TRUE_DUAL;
        cfg_a = '{SHAPE_X1, 1'b0};
        cfg_b = '{SHAPE_X9, 1'b1};
        for (int i = 0; i < 9; i++) wr(0, 13'(9 + i), {17'h0, pat[i]});
        wr(1, 13'h2, {9'h0, pb});
        idle();
        for (int i = 0; i < 9; i++) begin
            rd(0, 13'(18 + i), 1);
            `CHK("a_bit", {17'h0, pb[i]}, got)
        end
        rd(1, 13'h2, 2);
        `CHK("b_word2", {9'h0, pb}, got)
        rd(1, 13'h1, 1);
        `CHK("b_outreg_hold", {9'h0, pb}, got)
        @(negedge clk);
        `CHK("b_word1", {9'h0, pat}, rdata_b)
        $display("test mixed widths done");
    endtask

    // Wide shape in pseudo-dual and FIFO, folded to x9 in single port
    task automatic t_wide();
        ram_mode_t modes[2];
        modes = '{MODE_PSEUDO_DUAL, MODE_FIFO};
        cfg_a = '{SHAPE_X18, 1'b0};
        cfg_b = '{SHAPE_X18, 1'b0};
        for (int m = 0; m < 2; m++) begin
            cfg_mode = modes[m];
            wr(0, 13'(5 + m), 18'h2b3c1 ^ 18'(m));
            idle();
            rd(1, 13'(5 + m), 1);
            `CHK("x18_word", 18'h2b3c1 ^ 18'(m), got)
        end
        cfg_mode = MODE_SINGLE;
        wr(0, 13'h3, 18'h3ffff);
        idle();
        rd(0, 13'h3, 1);
        `CHK("x18_folded", 18'h001ff, got)
        $display("test wide shapes done");
    endtask

    // Flash preload, ROM-style use, then an all-zero preload
    task automatic t_preload();
        int n0;
        int ks[4];
        ks = '{0, 1, 200, 511};
        cfg_mode = MODE_PSEUDO_DUAL;
        cfg_a = '{SHAPE_X18, 1'b0};
        n0 = nflash;
        preload(1'b0, 4'ha);
        `CHK("flash_reads", 32'd512, 32'(nflash - n0))
        `CHK("flash_addr", {4'ha, 9'h1ff}, flash_rd_addr)
        foreach (ks[j]) begin
            rd(0, 13'(ks[j]), 1);
            `CHK("preload_word", {5'h15, 4'ha, 9'(ks[j])}, got)
        end
        req_a = '{1'b1, 1'b0, 13'h1, 18'h3ffff};
        @(negedge clk);
        idle();
        rd(0, 13'h1, 1);
        `CHK("rom_word", {5'h15, 4'ha, 9'h001}, got)
        n0 = nflash;
        preload(1'b1, 4'h3);
        `CHK("zero_reads", 32'd0, 32'(nflash - n0))
        rd(0, 13'h1, 1);
        `CHK("zero_word", 18'h00000, got)
        $display("test preload done");
    endtask

    //-----------------------------------------------------------
    // Main sequence
    //-----------------------------------------------------------
    initial begin
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        `CHK("rst_done", 1'b1, init_done)
        `CHK("rst_flash_en", 1'b0, flash_rd_en)
        `CHK("rst_rdata", 18'h00000, rdata_a)
        t_mixed();
        t_wide();
        t_preload();
        report_and_stop();
    end
endmodule

/* File: flash_store_model.sv */
/*
 * Model of the user-flash store that feeds the block's preload.
 * Assumes the block samples the word while its read request is high.
 */
module flash_store_model
    import ram_pkg::*;
(
    input wire logic clk, // Block clock
    input wire logic rd_en, // Read request
    input wire logic [ram_pkg::FLASH_ADDR_W-1:0] rd_addr, // Word address
    output logic [ram_pkg::DATA_W-1:0] rd_data // Word returned
);
    //-----------------------------------------------------------
    // Answer
    //-----------------------------------------------------------
    logic [DATA_W-1:0] junk_reg = 18'h2aaaa;

    // Junk flips every cycle so a stray sample never matches by luck
    always @(posedge clk) begin
        junk_reg <= ~junk_reg;
    end

    // Region and index form the word, so each region holds its own pattern
    assign rd_data = rd_en ? {5'h15, rd_addr} : junk_reg;
endmodule

/* File: port_stage.sv */
/*
 * One memory port: input capture registers and the optional output
 * register. Assumes the owner reads the array combinationally at the
 * captured address and hands the word back on arr_rdata.
 */
module port_stage
    import ram_pkg::*;
(
    input wire logic clk, // Port clock
    input wire logic sys_rst, // Synchronous reset, high
    input wire ram_pkg::port_req_t req, // Request from user logic
    input wire ram_pkg::port_cfg_t cfg, // Shape and output option
    input wire logic write_allow, // Mode and preload permit writes
    input wire logic [ram_pkg::DATA_W-1:0] arr_rdata, // Array word at cap.addr
    output ram_pkg::port_req_t cap, // Captured request
    output logic [ram_pkg::DATA_W-1:0] rdata // Read data to user logic
);
    import ram_pkg::*;

    typedef struct packed {
        port_req_t cap;
        logic [DATA_W-1:0] pipe;
        logic [DATA_W-1:0] rdata;
    } stage_t;

    stage_t st_reg;
    stage_t st_next;

    //-----------------------------------------------------------
    // Capture and output path
    //-----------------------------------------------------------
    // Read data follows the captured address every cycle, so no read strobe
    always_comb begin
        st_next = st_reg;
        if (req.en) begin
            st_next.cap = req;
            st_next.cap.we = req.we & write_allow;
        end else begin
            st_next.cap.we = 1'b0;
            st_next.cap.en = 1'b0;
        end
        st_next.pipe = arr_rdata;
        st_next.rdata = cfg.out_reg ? st_reg.pipe : arr_rdata;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '{cap: REQ_RST, pipe: DATA_RST, rdata: DATA_RST};
        end else begin
            st_reg <= st_next;
        end
    end

    assign cap = st_reg.cap;
    assign rdata = st_reg.rdata;

    a_addr_capture: assert property (@(posedge clk) disable iff (sys_rst)
        req.en |=> cap.addr == $past(req.addr) && cap.wdata == $past(req.wdata))
        else $error("Address or data not captured");
    a_bypass_latency: assert property (@(posedge clk) disable iff (sys_rst)
        !cfg.out_reg |=> rdata == $past(arr_rdata))
        else $error("Bypassed read data not one cycle late");
    a_regout_latency: assert property (@(posedge clk) disable iff (sys_rst)
        cfg.out_reg && !$past(sys_rst) |=> rdata == $past(arr_rdata, 2))
        else $error("Registered read data not two cycles late");

endmodule

/* File: ram_pkg.sv */
/*
 * Shared constants, types and helpers for the embedded RAM block.
 * Assumes one clock domain, a synchronous active-high reset and
 * a user-flash store that answers a read in the same cycle as its request.
 */
//---------------------------------------------------------------
// Function
//---------------------------------------------------------------
package ram_pkg;

    //-----------------------------------------------------------
    // Sizes
    //-----------------------------------------------------------
    localparam int unsigned ARRAY_BITS = 9216; // 512 x 18 bits
    localparam int unsigned ADDR_W = 13; // Deepest shape is 8192 x 1
    localparam int unsigned DATA_W = 18; // Widest shape is 512 x 18
    localparam int unsigned INIT_WORDS = 512; // Preload moves 18-bit words
    localparam int unsigned INIT_CNT_W = 9;
    localparam int unsigned REGION_W = 4;
    localparam int unsigned FLASH_ADDR_W = REGION_W + INIT_CNT_W;
    localparam logic [INIT_CNT_W-1:0] INIT_LAST = 9'h1ff;

    //-----------------------------------------------------------
    // Modes, shapes and states
    //-----------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_SINGLE = 4'h1,
        MODE_TRUE_DUAL = 4'h2,
        MODE_PSEUDO_DUAL = 4'h4,
        MODE_FIFO = 4'h8
    } ram_mode_t;

    typedef enum logic [2:0] {
        SHAPE_X1 = 3'h0,
        SHAPE_X2 = 3'h1,
        SHAPE_X4 = 3'h2,
        SHAPE_X9 = 3'h3,
        SHAPE_X18 = 3'h4
    } shape_t;

    typedef enum logic [3:0] {
        INIT_IDLE = 4'h1,
        INIT_CLEAR = 4'h2,
        INIT_FETCH = 4'h4,
        INIT_STORE = 4'h8
    } init_state_t;

    //-----------------------------------------------------------
    // Carriers
    //-----------------------------------------------------------
    typedef struct packed {
        logic en; // Port active this cycle
        logic we; // Write enable
        logic [ADDR_W-1:0] addr; // Word address in the port's shape
        logic [DATA_W-1:0] wdata; // Write data, low bits used
    } port_req_t;

    typedef struct packed {
        shape_t shape; // Depth-by-width choice
        logic out_reg; // 1 selects the output register
    } port_cfg_t;

    //-----------------------------------------------------------
    // Reset values
    //-----------------------------------------------------------
    localparam port_req_t REQ_RST = '0;
    localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
    localparam logic [INIT_CNT_W-1:0] CNT_RST = 9'h000;
    localparam logic [REGION_W-1:0] REGION_RST = 4'h0;
    localparam logic [FLASH_ADDR_W-1:0] FLASH_ADDR_RST = 13'h0000;

    // Width in bits of a shape
    function automatic logic [4:0] width_of(input shape_t s);
        logic [4:0] w;
        w = 5'h09;
        unique case (s)
            SHAPE_X1: w = 5'h01;
            SHAPE_X2: w = 5'h02;
            SHAPE_X4: w = 5'h04;
            SHAPE_X9: w = 5'h09;
            SHAPE_X18: w = 5'h12;
            default: w = 5'h09;
        endcase
        return w;
    endfunction

endpackage
